// *** tmr_pkg.sv ***
// Constants and state types for the 8-bit timer/counter with divider and PWM output
// Assumes a single 200 MHz clock and a simple strobe register port
`default_nettype none
package tmr_pkg;
   // Register offsets
   localparam logic [1:0] TMR_CTRL_OFS    = 2'h0;
   localparam logic [1:0] TMR_CMP_OFS     = 2'h1;
   localparam logic [1:0] TMR_CNT_OFS     = 2'h2;
   // Control field positions
   localparam int         TMR_MODE_LSB    = 0;
   localparam int         TMR_CLK_LSB     = 2;
   localparam int         TMR_RUN_BIT     = 5;
   // Clock select codes
   localparam logic [2:0] TMR_CLK_EXT     = 3'h7;
   localparam logic [2:0] TMR_CLK_SLOWOK  = 3'h0;
   // Divider shifts per clock code
   localparam logic [3:0] TMR_SHIFT_C0    = 4'hB;
   localparam logic [3:0] TMR_SHIFT_C1    = 4'h7;
   localparam logic [3:0] TMR_SHIFT_C2    = 4'h5;
   localparam logic [3:0] TMR_SHIFT_C3    = 4'h3;
   localparam logic [3:0] TMR_SHIFT_C4    = 4'h2;
   localparam logic [3:0] TMR_SHIFT_C5    = 4'h1;
   localparam logic [3:0] TMR_SHIFT_C6    = 4'h0;
   localparam logic [2:0] TMR_FS_LAST     = 3'h7;
   // Counter values
   localparam logic [7:0] TMR_CNT_ZERO    = 8'h00;
   localparam logic [7:0] TMR_CNT_ONE     = 8'h01;
   localparam logic [7:0] TMR_CNT_TOP     = 8'hFF;
   localparam logic [10:0] TMR_PRE_ZERO   = 11'h000;
   localparam logic [10:0] TMR_PRE_ONE    = 11'h001;

   typedef enum logic [1:0] {
      TMR_MODE_TIMER = 2'b00,
      TMR_MODE_RSVD  = 2'b01,
      TMR_MODE_PDO   = 2'b10,
      TMR_MODE_PWM   = 2'b11
   } tmr_mode_type;

   typedef struct packed {
      logic         run;
      logic [2:0]   clkSel;
      tmr_mode_type mode;
      logic [7:0]   cmpBuf;
      logic [7:0]   cmpAct;
      logic [7:0]   cnt;
      logic         outFf;
      logic [10:0]  pre;
      logic [2:0]   fsPre;
      logic         evMeta;
      logic         evSync;
      logic         evPrev;
      logic         irq;
      logic         pinN;
      logic [7:0]   rdData;
   } tmr_state_type;
endpackage
`default_nettype wire

// *** tmr_timer8.sv ***
// 8-bit up counter: timer, event counter, divider output and PWM output modes
// Assumes strobes and power-mode levels on ref_clk; only the event pin is asynchronous
//
// What this block does
// - Clock select 000-110 picks divided internal clocks, 111 the event pin in mode 00 only; modes 10 and 11 do not count on 111.
// - Mode field: 00 timer/event, 01 reserved, 10 divider output, 11 PWM.
// - Entering STOP power mode clears the run bit automatically.
// - Control register bits 7 and 6 read back as meaningless.
// - Reset leaves the compare register contents unchanged.
// - Timer mode counts internal clock; on match interrupts, clears, keeps counting.
// - Event mode counts event pin rising edges; match interrupts and clears.
// - Event mode checks the match only on the event pin falling edge.
// - Slow and sleep power modes ignore the external event clock.
// - Divider mode toggles the output flop, clears counter, interrupts on match.
// - Output pin shows the inverse of the output flop.
// - Output flop clears at reset and whenever the counter stops.
// - PWM match toggles the flop; overflow toggles again and interrupts.
// - PWM compare is double buffered; new value applies after the current cycle.
// - Starting in PWM moves the preloaded compare value into the active stage.
//
// Decided for this implementation: the strobed register port and the register offsets.
`default_nettype none
module tmr_timer8 (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // Register port
   input  wire logic [1:0] regAddr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output var  logic [7:0] rdData,
   // System clock and power state
   input  wire logic       lowFreqTick,
   input  wire logic       prescalerSourceSelect,
   input  wire logic       stopModeEntry,
   input  wire logic       slowPowerMode,
   input  wire logic       sleepPowerMode,
   // Pins and events
   input  wire logic       externalEventInput,
   output var  logic       dividerOutputPinN,
   output var  logic       timerInterrupt
);

   tmr_pkg::tmr_state_type sQ;
   tmr_pkg::tmr_state_type sD;

   function automatic logic tmrDivTick(input logic [10:0] pre, input logic [3:0] sh);
      logic [10:0] mask;
      mask = 11'((12'h001 << sh) - 12'h001);
      return (pre & mask) == mask;
   endfunction

   logic       slowSleep;
   logic       fsTick;
   logic       tick;
   logic       evRise;
   logic       evFall;
   logic [7:0] nextCnt;
   logic       ctrlWr;
   logic       cmpWr;

   always_comb begin
      slowSleep = slowPowerMode | sleepPowerMode;
      fsTick    = lowFreqTick & (sQ.fsPre == tmr_pkg::TMR_FS_LAST);
      evRise    = sQ.evSync & ~sQ.evPrev & ~slowSleep;
      evFall    = ~sQ.evSync & sQ.evPrev & ~slowSleep;
      nextCnt   = sQ.cnt + tmr_pkg::TMR_CNT_ONE;
      ctrlWr    = wrStb & (regAddr == tmr_pkg::TMR_CTRL_OFS);
      cmpWr     = wrStb & (regAddr == tmr_pkg::TMR_CMP_OFS);
      // Count source select
      case (sQ.clkSel)
         3'h0: tick = (prescalerSourceSelect | slowSleep) ? fsTick
                      : tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C0);
         3'h1: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C1);
         3'h2: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C2);
         3'h3: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C3);
         3'h4: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C4);
         3'h5: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C5);
         3'h6: tick = ~slowSleep & tmrDivTick(sQ.pre, tmr_pkg::TMR_SHIFT_C6);
         default: tick = 1'b0;
      endcase
   end

   always_comb begin
      sD        = sQ;
      sD.irq    = 1'b0;
      // Prescalers and event pin synchroniser
      sD.pre    = sQ.pre + tmr_pkg::TMR_PRE_ONE;
      if (lowFreqTick) begin
         sD.fsPre = sQ.fsPre + 3'h1;
      end
      sD.evMeta = externalEventInput;
      sD.evSync = sQ.evMeta;
      sD.evPrev = sQ.evSync;
      // Counting
      if (sQ.run) begin
         case (sQ.mode)
            tmr_pkg::TMR_MODE_TIMER: begin
               if (sQ.clkSel == tmr_pkg::TMR_CLK_EXT) begin
                  if (evRise) begin
                     sD.cnt = nextCnt;
                  end
                  if (evFall && sQ.cnt == sQ.cmpBuf) begin
                     sD.cnt = tmr_pkg::TMR_CNT_ZERO;
                     sD.irq = 1'b1;
                  end
               end else if (tick) begin
                  if (nextCnt == sQ.cmpBuf) begin
                     sD.cnt = tmr_pkg::TMR_CNT_ZERO;
                     sD.irq = 1'b1;
                  end else begin
                     sD.cnt = nextCnt;
                  end
               end
            end
            tmr_pkg::TMR_MODE_PDO: begin
               if (tick) begin
                  if (nextCnt == sQ.cmpBuf) begin
                     sD.cnt   = tmr_pkg::TMR_CNT_ZERO;
                     sD.outFf = ~sQ.outFf;
                     sD.irq   = 1'b1;
                  end else begin
                     sD.cnt = nextCnt;
                  end
               end
            end
            tmr_pkg::TMR_MODE_PWM: begin
               if (tick) begin
                  sD.cnt = nextCnt;
                  if (sQ.cnt == tmr_pkg::TMR_CNT_TOP) begin
                     sD.outFf  = ~sQ.outFf;
                     sD.irq    = 1'b1;
                     sD.cmpAct = sQ.cmpBuf;
                  end else if (nextCnt == sQ.cmpAct) begin
                     sD.outFf = ~sQ.outFf;
                  end
               end
            end
            default: begin
               sD.cnt = sQ.cnt;
            end
         endcase
      end
      // Register writes
      if (ctrlWr) begin
         sD.run    = wrData[tmr_pkg::TMR_RUN_BIT];
         sD.clkSel = wrData[tmr_pkg::TMR_CLK_LSB +: 3];
         sD.mode   = tmr_pkg::tmr_mode_type'(wrData[tmr_pkg::TMR_MODE_LSB +: 2]);
         if (!wrData[tmr_pkg::TMR_RUN_BIT]) begin
            sD.cnt   = tmr_pkg::TMR_CNT_ZERO;
            sD.outFf = 1'b0;
            sD.irq   = 1'b0;
         end else if (!sQ.run) begin
            sD.cnt    = tmr_pkg::TMR_CNT_ZERO;
            sD.cmpAct = sQ.cmpBuf;
         end
      end
      if (cmpWr) begin
         sD.cmpBuf = wrData;
      end
      if (stopModeEntry) begin
         sD.run   = 1'b0;
         sD.cnt   = tmr_pkg::TMR_CNT_ZERO;
         sD.outFf = 1'b0;
      end
      sD.pinN = ~sD.outFf;
      // Read data, valid only in the cycle after the strobe
      sD.rdData = 8'h00;
      if (rdStb) begin
         case (regAddr)
            tmr_pkg::TMR_CTRL_OFS: sD.rdData = {2'b00, sQ.run, sQ.clkSel, sQ.mode};
            tmr_pkg::TMR_CMP_OFS:  sD.rdData = sQ.cmpBuf;
            tmr_pkg::TMR_CNT_OFS:  sD.rdData = sQ.cnt;
            default:               sD.rdData = 8'h00;
         endcase
      end
      // Reset keeps the compare buffer
      if (srst) begin
         sD        = '0;
         sD.mode   = tmr_pkg::TMR_MODE_TIMER;
         sD.pre    = tmr_pkg::TMR_PRE_ZERO;
         sD.outFf  = 1'b0;
         sD.pinN   = 1'b1;
         sD.cmpBuf = sQ.cmpBuf;
      end
   end

   always_ff @(posedge ref_clk) begin
      sQ <= sD;
   end

   assign rdData            = sQ.rdData;
   assign dividerOutputPinN = sQ.pinN;
   assign timerInterrupt    = sQ.irq;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_stopWrite;
      ctrlWr && !wrData[tmr_pkg::TMR_RUN_BIT];
   endsequence

   sequence s_pwmStart;
      ctrlWr && wrData[tmr_pkg::TMR_RUN_BIT] && !sQ.run && !stopModeEntry
         && wrData[tmr_pkg::TMR_MODE_LSB +: 2] == tmr_pkg::TMR_MODE_PWM;
   endsequence

   sequence s_timerMatch;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_TIMER && sQ.clkSel != tmr_pkg::TMR_CLK_EXT
         && tick && nextCnt == sQ.cmpBuf && !wrStb && !stopModeEntry;
   endsequence

   property p_stopClear;
      s_stopWrite |=> sQ.cnt == tmr_pkg::TMR_CNT_ZERO && !sQ.outFf && !sQ.run;
   endproperty
   a_stopClear: assert property (p_stopClear) else $error("stop did not clear");

   property p_pinInverse;
      dividerOutputPinN == ~sQ.outFf;
   endproperty
   a_pinInverse: assert property (p_pinInverse) else $error("pin not inverted");

   property p_timerMatch;
      s_timerMatch |=> timerInterrupt && sQ.cnt == tmr_pkg::TMR_CNT_ZERO;
   endproperty
   a_timerMatch: assert property (p_timerMatch) else $error("timer match lost");

   property p_eventHighNoIrq;
      sQ.run && sQ.clkSel == tmr_pkg::TMR_CLK_EXT && sQ.evSync && sQ.evPrev
         |=> !timerInterrupt;
   endproperty
   a_eventHighNoIrq: assert property (p_eventHighNoIrq) else $error("irq while high");

   property p_pdoToggle;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_PDO && tick && nextCnt == sQ.cmpBuf
         && !wrStb && !stopModeEntry |=> timerInterrupt && sQ.outFf != $past(sQ.outFf);
   endproperty
   a_pdoToggle: assert property (p_pdoToggle) else $error("divider toggle lost");

   property p_pwmOverflow;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_PWM && tick && sQ.cnt == tmr_pkg::TMR_CNT_TOP
         && !wrStb && !stopModeEntry
         |=> timerInterrupt && sQ.cmpAct == $past(sQ.cmpBuf) && sQ.outFf != $past(sQ.outFf);
   endproperty
   a_pwmOverflow: assert property (p_pwmOverflow) else $error("pwm overflow wrong");

   property p_pwmHold;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_PWM && !(tick && sQ.cnt == tmr_pkg::TMR_CNT_TOP)
         && !ctrlWr |=> sQ.cmpAct == $past(sQ.cmpAct);
   endproperty
   a_pwmHold: assert property (p_pwmHold) else $error("pwm compare changed early");

   property p_pwmStart;
      s_pwmStart |=> sQ.cmpAct == $past(sQ.cmpBuf) && sQ.run;
   endproperty
   a_pwmStart: assert property (p_pwmStart) else $error("pwm preload missed");

   property p_stopMode;
      stopModeEntry |=> !sQ.run && !sQ.outFf;
   endproperty
   a_stopMode: assert property (p_stopMode) else $error("stop mode kept run");

   property p_slowNoTick;
      slowSleep && sQ.clkSel != tmr_pkg::TMR_CLK_SLOWOK |-> !tick && !evRise;
   endproperty
   a_slowNoTick: assert property (p_slowNoTick) else $error("clock in slow mode");

   sequence s_eventFallMatch;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_TIMER && sQ.clkSel == tmr_pkg::TMR_CLK_EXT
         && evFall && sQ.cnt == sQ.cmpBuf && !wrStb && !stopModeEntry;
   endsequence

   property p_eventMatch;
      s_eventFallMatch |=> timerInterrupt && sQ.cnt == tmr_pkg::TMR_CNT_ZERO;
   endproperty
   a_eventMatch: assert property (p_eventMatch) else $error("event match lost");

   property p_eventRise;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_TIMER && sQ.clkSel == tmr_pkg::TMR_CLK_EXT
         && evRise && !wrStb && !stopModeEntry
         |=> sQ.cnt == $past(nextCnt) && !timerInterrupt;
   endproperty
   a_eventRise: assert property (p_eventRise) else $error("event edge not counted");

   property p_resetOut;
      disable iff (1'b0) srst |=> !sQ.outFf && dividerOutputPinN && !timerInterrupt && !sQ.run;
   endproperty
   a_resetOut: assert property (p_resetOut) else $error("reset left output set");

   property p_pdoCount;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_PDO && tick && nextCnt != sQ.cmpBuf
         && !wrStb && !stopModeEntry
         |=> sQ.cnt == $past(nextCnt) && sQ.outFf == $past(sQ.outFf);
   endproperty
   a_pdoCount: assert property (p_pdoCount) else $error("divider count wrong");

   property p_pwmMatch;
      sQ.run && sQ.mode == tmr_pkg::TMR_MODE_PWM && tick && sQ.cnt != tmr_pkg::TMR_CNT_TOP
         && nextCnt == sQ.cmpAct && !wrStb && !stopModeEntry
         |=> sQ.outFf != $past(sQ.outFf) && !timerInterrupt;
   endproperty
   a_pwmMatch: assert property (p_pwmMatch) else $error("pwm match toggle lost");

endmodule
`default_nettype wire

// *** tmr_event_src.sv ***
// Partner model: source that drives the external event input pin
// Assumes one pulse per go request; the pin idles low between pulses
`default_nettype none
module tmr_event_src (
   // Clock
   input  wire logic       ref_clk,
   // Pulse request
   input  wire logic       go,
   input  wire logic [7:0] highLen,
   // Pin
   output var  logic       eventPin,
   output var  logic       busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] cnt = 9'h000;
   // High phase of highLen cycles, then a low phase of four cycles
   always @(posedge ref_clk) begin
      if (go && cnt == 9'h000) begin
         cnt <= {1'b0, highLen} + 9'h004;
      end else if (cnt != 9'h000) begin
         cnt <= cnt - 9'h001;
      end
   end
   assign eventPin = (cnt > 9'h004);
   assign busy     = (cnt != 9'h000);
endmodule
`default_nettype wire

// *** test_tmr_timer8.sv ***
// Testbench for the 8-bit timer/counter
// Assumes the design's registered read port and the event source partner model
`default_nettype none
module test_tmr_timer8;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, srst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, lowFreqTick = 1'b0;
   logic prescalerSourceSelect = 1'b1, stopModeEntry = 1'b0;
   logic slowPowerMode = 1'b0, sleepPowerMode = 1'b0, go = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] wrData = 8'h00, highLen = 8'h04, rdData, rd;
   logic eventPin, busy, pinN, irq, p;
   logic portLatch = 1'b1;
   wire logic portPin;
   assign portPin = pinN & portLatch;
   logic [15:0] n, lo;
   int miscompares = 0, num_checks = 0, irqCnt = 0, cyc = 0;
   tmr_timer8 u_dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .lowFreqTick(lowFreqTick),
      .prescalerSourceSelect(prescalerSourceSelect), .stopModeEntry(stopModeEntry),
      .slowPowerMode(slowPowerMode), .sleepPowerMode(sleepPowerMode),
      .externalEventInput(eventPin), .dividerOutputPinN(pinN), .timerInterrupt(irq));
   tmr_event_src u_src (.ref_clk(ref_clk), .go(go), .highLen(highLen), .eventPin(eventPin),
      .busy(busy));
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      lowFreqTick <= (cyc % 4 == 2);
      if (irq === 1'b1) irqCnt <= irqCnt + 1;
      if (cyc == 40000) begin
         miscompares = miscompares + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
   endtask
   task automatic rdr(input logic [1:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask
   // Waits for the next interrupt; counts cycles and cycles with the pin low
   task automatic wait_irq(output logic [15:0] c, output logic [15:0] l);
      int k;
      k = irqCnt;
      c = 16'h0000;
      l = 16'h0000;
      while (irqCnt == k && c < 16'h1000) begin
         @(posedge ref_clk);
         #1 c = c + 16'h0001;
         if (portPin === 1'b0) l = l + 16'h0001;
      end
   endtask
   // Sets mode and clock with run low, then starts with the same fields
   task automatic start(input logic [2:0] ck, input logic [1:0] md, input logic [7:0] cmp);
      wr(2'h1, cmp);
      wr(2'h0, {3'b000, ck, md});
      wr(2'h0, {3'b001, ck, md});
   endtask
   task automatic pulse(input logic [7:0] h);
      @(posedge ref_clk);
      highLen <= h;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      repeat (300) if (busy === 1'b1) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic t_regs();
      rdr(2'h0, rd);
      chk("ctrl reset", {10'h000, rd[5:0]}, 16'h0000);
      chk("pin idle", pinN, 16'h0001);
      wr(2'h1, 8'h5A);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rdr(2'h1, rd);
      chk("cmp kept", rd, 16'h005A);
      wr(2'h3, 8'h3F);
      rdr(2'h3, rd);
      chk("unmapped", rd, 16'h0000);
      rdr(2'h0, rd);
      chk("ctrl after unmapped", rd[5:0], 16'h0000);
   endtask
   task automatic t_timer();
      logic [2:0] ck [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
      logic [15:0] tk [4] = '{16'h0020, 16'h0080, 16'h0020, 16'h0008};
      for (int i = 0; i < 4; i++) begin
         start(ck[i], 2'b00, 8'h02);
         wait_irq(n, lo);
         wait_irq(n, lo);
         chk("timer period", n, tk[i] * 16'h0002);
         repeat (tk[i]) @(posedge ref_clk);
         rdr(2'h2, rd);
         chk("running count", rd, 16'h0001);
         wr(2'h0, {3'b000, ck[i], 2'b00});
         rdr(2'h2, rd);
         chk("stopped count", rd, 16'h0000);
      end
      prescalerSourceSelect <= 1'b0;
      start(3'h0, 2'b00, 8'h01);
      wait_irq(n, lo);
      wait_irq(n, lo);
      chk("fast source period", n, 16'h0800);
      wr(2'h0, 8'h00);
      prescalerSourceSelect <= 1'b1;
   endtask
   task automatic t_pdo();
      start(3'h2, 2'b10, 8'h02);
      wait_irq(n, lo);
      p = pinN;
      wait_irq(n, lo);
      chk("pdo period", n, 16'h0040);
      chk("pdo toggle", pinN, {15'h0000, ~p});
      wait_irq(n, lo);
      chk("pdo low before stop", pinN, 16'h0000);
      wr(2'h0, 8'h0A);
      repeat (2) @(posedge ref_clk);
      chk("pdo stop pin", pinN, 16'h0001);
   endtask
   task automatic t_pwm();
      start(3'h6, 2'b11, 8'h40);
      wait_irq(n, lo);
      chk("pwm first low", lo, 16'h00C0);
      wr(2'h1, 8'hC0);
      wait_irq(n, lo);
      chk("pwm old low", lo, 16'h00C0);
      wait_irq(n, lo);
      chk("pwm new low", lo, 16'h0040);
      chk("pwm period", n, 16'h0100);
      repeat (208) @(posedge ref_clk);
      #1 chk("pwm low before stop", pinN, 16'h0000);
      @(posedge ref_clk);
      stopModeEntry <= 1'b1;
      @(posedge ref_clk);
      stopModeEntry <= 1'b0;
      rdr(2'h0, rd);
      chk("stop entry run", rd[5], 16'h0000);
      chk("stop entry pin", pinN, 16'h0001);
   endtask
   task automatic t_event();
      int k;
      start(3'h7, 2'b00, 8'h03);
      pulse(8'h04);
      pulse(8'h02);
      rdr(2'h2, rd);
      chk("event count", rd, 16'h0002);
      k = irqCnt;
      @(posedge ref_clk);
      highLen <= 8'h28;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk("no match while high", irqCnt - k, 16'h0000);
      repeat (20) @(posedge ref_clk);
      chk("match on fall", irqCnt - k, 16'h0001);
      slowPowerMode <= 1'b1;
      pulse(8'h04);
      slowPowerMode <= 1'b0;
      sleepPowerMode <= 1'b1;
      pulse(8'h04);
      sleepPowerMode <= 1'b0;
      rdr(2'h2, rd);
      chk("low power events", rd, 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      t_timer();
      t_pdo();
      t_pwm();
      t_event();
      end_sim();
   end
endmodule
`default_nettype wire
